// File: hdl/rgsrt_pkg.sv
// constants and types of the remap status and root table register bank
package rgsrt_pkg;
	// apb address width used by the slave
	localparam int RGSRT_AW = 12;
	// register byte offsets
	localparam logic [11:0] RGSRT_OFS_CMD = 12'h030;
	localparam logic [11:0] RGSRT_OFS_STS = 12'h01c;
	localparam logic [11:0] RGSRT_OFS_RTA_LO = 12'h020;
	localparam logic [11:0] RGSRT_OFS_RTA_HI = 12'h024;
	// command and status bit positions (shared layout)
	localparam int RGSRT_BIT_TE = 31;
	localparam int RGSRT_BIT_RTP = 30;
	localparam int RGSRT_BIT_FLOG = 29;
	localparam int RGSRT_BIT_AFL = 28;
	localparam int RGSRT_BIT_WBF = 27;
	localparam int RGSRT_BIT_QI = 26;
	localparam int RGSRT_BIT_IR = 25;
	localparam int RGSRT_BIT_IRTP = 24;
	localparam int RGSRT_BIT_CFI = 23;
	// reserved low part of the status word
	localparam int RGSRT_STS_RSV_W = 23;
	// root table address register fields
	localparam int RGSRT_RTA_LSB = 12;
	localparam int RGSRT_TTM_LSB = 10;
	localparam int RGSRT_TTM_W = 2;
	localparam int RGSRT_RSV_LO_W = 10;
	localparam logic [1:0] RGSRT_TTM_LEGACY = 2'h0;
	localparam logic [1:0] RGSRT_TTM_SCALABLE = 2'h1;
	// handshake operations, index into the op arrays
	localparam int RGSRT_OP_N = 4;
	localparam int RGSRT_OP_ROOT = 0;
	localparam int RGSRT_OP_FLOG = 1;
	localparam int RGSRT_OP_IRTP = 2;
	localparam int RGSRT_OP_WBF = 3;
	localparam int RGSRT_OP_BIT [RGSRT_OP_N] = '{30, 29, 24, 27};
	// operation latency counter
	localparam int RGSRT_CNT_W = 8;
	localparam logic [7:0] RGSRT_OP_CYCLES = 8'h04;
	// status word fields, msb first
	typedef struct packed {
		logic translation_on_flag;
		logic root_pointer_set_flag;
		logic fault_log_pointer_flag;
		logic adv_fault_logging_on_flag;
		logic write_flush_pending_flag;
		logic queued_invalidation_on_flag;
		logic irq_remap_on_flag;
		logic irq_table_pointer_set_flag;
		logic compat_irq_pass_flag;
	} rgsrt_status_t;
	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rgsrt_apb_req_t;
	// apb answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rgsrt_apb_rsp_t;
	// state of one handshake operation
	typedef enum logic {
		RGSRT_IDLE = 1'b0,
		RGSRT_BUSY = 1'b1
	} rgsrt_op_state_t;
endpackage

// File: hdl/rgsrt_top.sv
// remap global status and root table address registers behind apb
//
// Overview of operation
// - status bit 31 shows translation on
// - root pointer command clears status bit 30
// - bit 30 sets when root base adopted
// - fault log command clears, latch sets bit 29
// - bit 28 shows advanced fault logging enabled
// - flush command sets bit 27, completion clears
// - bit 26 shows queued invalidation enabled
// - bit 25 shows interrupt remapping enabled
// - irq table command clears status bit 24
// - bit 24 sets when irq table adopted
// - bit 23 shows compatibility interrupts passed
// - status at 01ch, resets zero, 22:0 zero
// - root table base in bits 63:12
// - base bits at and above width ignored
// - reads return last written address value
// - mode 00 legacy, 01 scalable, rest reserved
// - address register at 020h, resets zero
// - compatibility control update reflected in status
// - command bit 24 write-only, zero ignored
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rgsrt_top #(
	parameter int HOST_ADDR_W = 48,
	parameter bit ADV_FAULT_LOG = 1'b1,
	parameter bit WB_FLUSH = 1'b1,
	parameter logic [7:0] OP_CYCLES = rgsrt_pkg::RGSRT_OP_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire rgsrt_pkg::rgsrt_apb_req_t apb_req,
	output var rgsrt_pkg::rgsrt_apb_rsp_t apb_rsp,
	input wire logic [63:12] fault_log_ptr,
	input wire logic [63:12] irq_table_base,
	output var rgsrt_pkg::rgsrt_status_t status,
	output var logic [63:12] active_root_base,
	output var logic [1:0] active_ttm,
	output var logic active_ttm_legacy,
	output var logic active_ttm_scalable,
	output var logic [63:12] active_fault_log_ptr,
	output var logic [63:12] active_irq_table_base
);
	import rgsrt_pkg::*;

	// register map, byte offsets on the apb side:
	//   01ch status, read only, writes refused with an error
	//   020h root table address, low word with the mode field
	//   024h root table address, high word
	//   030h command, write only, reads give zero
	// any other offset answers with an error and no effect

	// implemented base bits; shifting past 63 yields all ones
	// bits at and above the host width are neither stored nor
	// shown, so software reading back sees what hardware uses
	localparam logic [63:0] HAW_MASK =
		(64'h1 << HOST_ADDR_W) - 64'h1;

	// true when the apb address selects the given offset
	// full compare: a misaligned offset never aliases a register
	function automatic logic hit(
		input logic [RGSRT_AW-1:0] addr,
		input logic [RGSRT_AW-1:0] ofs
	);
		hit = (addr == ofs);
	endfunction

	// true for the reserved mode encodings
	// those select no table format at all
	function automatic logic ttm_reserved(
		input logic [1:0] mode
	);
		ttm_reserved = (mode != RGSRT_TTM_LEGACY) &&
			(mode != RGSRT_TTM_SCALABLE);
	endfunction

	// software visible root table address state
	logic [63:12] rta_base; // stored base, masked
	logic [1:0] rta_ttm; // stored mode field
	logic [63:12] next_rta_base;
	logic [1:0] next_rta_ttm;

	// bus answer next values; the answer is a register so that
	// the read mux never sits on the bus return path
	rgsrt_apb_rsp_t next_rsp;

	// transfer phases
	logic access_first; // first access cycle
	logic fire; // edge that completes a transfer
	logic wr_fire; // completing write
	logic cmd_wr; // completing command write
	logic [31:0] wdata; // write data shorthand
	logic [RGSRT_AW-1:0] addr; // address shorthand

	// op handshake state, one slot per operation; the slot
	// order follows the op index constants of the package
	rgsrt_op_state_t op_state [RGSRT_OP_N];
	rgsrt_op_state_t next_op_state [RGSRT_OP_N];
	logic [RGSRT_CNT_W-1:0] op_cnt [RGSRT_OP_N];
	logic [RGSRT_CNT_W-1:0] next_op_cnt [RGSRT_OP_N];
	logic [RGSRT_OP_N-1:0] op_start; // command accepted
	logic [RGSRT_OP_N-1:0] op_done; // one-cycle completion

	// status and active copies next values
	rgsrt_status_t next_status;
	logic [63:12] next_active_root_base;
	logic [1:0] next_active_ttm;
	logic next_active_ttm_legacy;
	logic next_active_ttm_scalable;
	logic [63:12] next_active_fault_log_ptr;
	logic [63:12] next_active_irq_table_base;

	// apb phase decode; pready comes from a flop, one wait state
	// the slave ignores the setup cycle and picks its answer in
	// the first access cycle; the cost is a fixed wait state,
	// the gain is that prdata and pready leave flops
	always_comb begin
		addr = apb_req.paddr;
		wdata = apb_req.pwdata;
		access_first = apb_req.psel && apb_req.penable &&
			!apb_rsp.pready;
		fire = apb_req.psel && apb_req.penable &&
			apb_rsp.pready;
		wr_fire = fire && apb_req.pwrite;
		cmd_wr = wr_fire && hit(addr, RGSRT_OFS_CMD);
	end

	// bus answer: read data and error chosen in first access cycle
	// prdata is kept between transfers; only pready and the
	// error are strobes
	always_comb begin
		next_rsp = apb_rsp;
		next_rsp.pready = access_first;
		if (access_first) begin
			next_rsp.prdata = 32'h0000_0000;
			next_rsp.pslverr = 1'b0;
			if (hit(addr, RGSRT_OFS_STS)) begin
				// status is read only, a write is refused
				next_rsp.prdata = {status,
					{RGSRT_STS_RSV_W{1'b0}}};
				next_rsp.pslverr = apb_req.pwrite;
			end else if (hit(addr, RGSRT_OFS_RTA_LO)) begin
				// last written value, active or not
				next_rsp.prdata = {rta_base[31:12],
					rta_ttm,
					{RGSRT_RSV_LO_W{1'b0}}};
			end else if (hit(addr, RGSRT_OFS_RTA_HI)) begin
				next_rsp.prdata = rta_base[63:32];
			end else if (hit(addr, RGSRT_OFS_CMD)) begin
				// write only; reads give zero
				next_rsp.prdata = 32'h0000_0000;
			end else begin
				// unmapped offset
				next_rsp.pslverr = 1'b1;
			end
		end else begin
			// the error stands only beside pready, so it drops
			// at the edge that ends the transfer
			next_rsp.pslverr = 1'b0;
		end
	end

	// bus answer registers
	// all answer fields reset low, so no false ready after reset
	always_ff @(posedge clock) begin
		if (!nrst) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp <= next_rsp;
		end
	end

	// root table address register writes take effect on the fire edge
	// the halves are written one at a time; a new base is only
	// used once the root pointer command completes
	always_comb begin
		next_rta_base = rta_base;
		next_rta_ttm = rta_ttm;
		if (wr_fire && hit(addr, RGSRT_OFS_RTA_LO)) begin
			// unimplemented high bits never stored
			next_rta_base[31:12] = wdata[31:12] &
				HAW_MASK[31:12];
			next_rta_ttm = wdata[RGSRT_TTM_LSB +: RGSRT_TTM_W];
		end else if (wr_fire && hit(addr, RGSRT_OFS_RTA_HI)) begin
			next_rta_base[63:32] = wdata &
				HAW_MASK[63:32];
		end
	end

	// root table address registers, reset to zero
	// mode resets to the legacy encoding, which is all zero
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rta_base <= '0;
			rta_ttm <= RGSRT_TTM_LEGACY;
		end else begin
			rta_base <= next_rta_base;
			rta_ttm <= next_rta_ttm;
		end
	end

	// one handshake engine per pointer or flush operation
	// each engine idles until its command bit, stays busy for the
	// programmed latency, then gives a one-cycle completion strobe;
	// the latency stands in for the fetch of the new structure
	genvar g;
	generate
		for (g = 0; g < RGSRT_OP_N; g++) begin : g_op
			// flush only exists when the platform needs it
			localparam bit PRESENT =
				(g != RGSRT_OP_WBF) || WB_FLUSH;

			// a one in the command bit starts; zero does nothing
			always_comb begin
				op_start[g] = PRESENT && cmd_wr &&
					wdata[RGSRT_OP_BIT[g]];
				op_done[g] = (op_state[g] == RGSRT_BUSY) &&
					(op_cnt[g] == '0) && !op_start[g];
			end

			// count down the latency of the operation
			always_comb begin
				next_op_state[g] = op_state[g];
				next_op_cnt[g] = op_cnt[g];
				case (op_state[g])
					RGSRT_IDLE: begin
						// waiting for a command
						if (op_start[g]) begin
							next_op_state[g] = RGSRT_BUSY;
							next_op_cnt[g] = OP_CYCLES - 8'h01;
						end
					end
					RGSRT_BUSY: begin
						// counting toward completion
						if (op_start[g]) begin
							// a repeat command restarts it
							next_op_cnt[g] = OP_CYCLES - 8'h01;
						end else if (op_cnt[g] == '0) begin
							next_op_state[g] = RGSRT_IDLE;
						end else begin
							next_op_cnt[g] = op_cnt[g] - 8'h01;
						end
					end
					default: begin
						// unreachable; park the engine
						next_op_state[g] = RGSRT_IDLE;
						next_op_cnt[g] = '0;
					end
				endcase
			end

			// handshake registers
			// engines reset idle, so no completion follows reset
			always_ff @(posedge clock) begin
				if (!nrst) begin
					op_state[g] <= RGSRT_IDLE;
					op_cnt[g] <= '0;
				end else begin
					op_state[g] <= next_op_state[g];
					op_cnt[g] <= next_op_cnt[g];
				end
			end
		end
	endgenerate

	// status flags: enables follow the command write at once,
	// with no handshake, since the enables need no table fetch;
	// pointer flags drop on the command and rise on completion
	always_comb begin
		next_status = status;
		if (cmd_wr) begin
			next_status.translation_on_flag = wdata[RGSRT_BIT_TE];
			// stays zero where advanced logging is left out
			next_status.adv_fault_logging_on_flag = ADV_FAULT_LOG &&
				wdata[RGSRT_BIT_AFL];
			next_status.queued_invalidation_on_flag = wdata[RGSRT_BIT_QI];
			next_status.irq_remap_on_flag = wdata[RGSRT_BIT_IR];
			// only meaningful while remapping on and
			// extended interrupt mode off
			next_status.compat_irq_pass_flag = wdata[RGSRT_BIT_CFI];
		end
		// a new command outranks a completion in the same cycle,
		// since the completion belongs to the older request
		if (op_start[RGSRT_OP_ROOT]) begin
			next_status.root_pointer_set_flag = 1'b0;
		end else if (op_done[RGSRT_OP_ROOT]) begin
			next_status.root_pointer_set_flag = 1'b1;
		end
		if (op_start[RGSRT_OP_FLOG]) begin
			next_status.fault_log_pointer_flag = 1'b0;
		end else if (op_done[RGSRT_OP_FLOG]) begin
			next_status.fault_log_pointer_flag = 1'b1;
		end
		if (op_start[RGSRT_OP_IRTP]) begin
			next_status.irq_table_pointer_set_flag = 1'b0;
		end else if (op_done[RGSRT_OP_IRTP]) begin
			next_status.irq_table_pointer_set_flag = 1'b1;
		end
		// flush runs the other way round: busy while high
		if (op_start[RGSRT_OP_WBF]) begin
			next_status.write_flush_pending_flag = 1'b1;
		end else if (op_done[RGSRT_OP_WBF]) begin
			next_status.write_flush_pending_flag = 1'b0;
		end
	end

	// status register, every field resets to zero
	// reserved low bits are not stored; the read mux adds them
	always_ff @(posedge clock) begin
		if (!nrst) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// active copies change only at completion, so a plain register
	// write never moves the pointer translation uses
	// the fault log pointer is copied as given: its source
	// register already holds only implemented bits
	always_comb begin
		next_active_root_base = active_root_base;
		next_active_ttm = active_ttm;
		next_active_ttm_legacy = active_ttm_legacy;
		next_active_ttm_scalable = active_ttm_scalable;
		next_active_fault_log_ptr = active_fault_log_ptr;
		next_active_irq_table_base = active_irq_table_base;
		if (op_done[RGSRT_OP_ROOT]) begin
			next_active_root_base = rta_base;
			next_active_ttm = rta_ttm;
			// reserved encodings select neither table format
			next_active_ttm_legacy =
				(rta_ttm == RGSRT_TTM_LEGACY);
			next_active_ttm_scalable =
				(rta_ttm == RGSRT_TTM_SCALABLE) &&
				!ttm_reserved(rta_ttm);
		end
		if (op_done[RGSRT_OP_FLOG]) begin
			next_active_fault_log_ptr = fault_log_ptr;
		end
		if (op_done[RGSRT_OP_IRTP]) begin
			next_active_irq_table_base =
				irq_table_base & HAW_MASK[63:12];
		end
	end

	// active copy registers; mode resets to legacy
	// the legacy flag is the only output that resets high
	always_ff @(posedge clock) begin
		if (!nrst) begin
			active_root_base <= '0;
			active_ttm <= RGSRT_TTM_LEGACY;
			active_ttm_legacy <= 1'b1;
			active_ttm_scalable <= 1'b0;
			active_fault_log_ptr <= '0;
			active_irq_table_base <= '0;
		end else begin
			active_root_base <= next_active_root_base;
			active_ttm <= next_active_ttm;
			active_ttm_legacy <= next_active_ttm_legacy;
			active_ttm_scalable <= next_active_ttm_scalable;
			active_fault_log_ptr <= next_active_fault_log_ptr;
			active_irq_table_base <= next_active_irq_table_base;
		end
	end

endmodule
`default_nettype wire

// File: tb/rgsrt_properties.sv
// concurrent checks on the ports of the remap status register bank
`timescale 1ns/1ps
`default_nettype none
module rgsrt_checker #(
	parameter int OP_CYCLES = 4
) (
	input wire logic clock,
	input wire logic nrst,
	input wire rgsrt_pkg::rgsrt_apb_req_t apb_req,
	input wire rgsrt_pkg::rgsrt_apb_rsp_t apb_rsp,
	input wire rgsrt_pkg::rgsrt_status_t status,
	input wire logic [63:12] active_root_base,
	input wire logic [1:0] active_ttm,
	input wire logic active_ttm_legacy,
	input wire logic active_ttm_scalable
);
	import rgsrt_pkg::*;
	localparam int OPC_M1 = OP_CYCLES - 1;
	logic done; // a transfer completes at this edge
	logic cmd_wr; // a command write lands at this edge
	logic [31:0] last_wd; // write data of the previous cycle
	assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;
	assign cmd_wr = done && apb_req.pwrite && apb_req.paddr == RGSRT_OFS_CMD;
	// status follows the command data one edge later, so keep it
	always_ff @(posedge clock) begin
		last_wd <= apb_req.pwdata;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	chk_root_flag: assert property (
		cmd_wr && apb_req.pwdata[30] |=> !status.root_pointer_set_flag ##OPC_M1 !status.root_pointer_set_flag
		##1 status.root_pointer_set_flag) else $error("root pointer flag timing wrong");
	chk_flog_flag: assert property (
		cmd_wr && apb_req.pwdata[29] |=> !status.fault_log_pointer_flag ##OPC_M1 !status.fault_log_pointer_flag
		##1 status.fault_log_pointer_flag) else $error("fault log flag timing wrong");
	chk_irq_flag: assert property (
		cmd_wr && apb_req.pwdata[24] |=> !status.irq_table_pointer_set_flag ##OPC_M1 !status.irq_table_pointer_set_flag
		##1 status.irq_table_pointer_set_flag) else $error("irq table flag timing wrong");
	chk_flush_flag: assert property (
		cmd_wr && apb_req.pwdata[27] |=> status.write_flush_pending_flag ##OP_CYCLES !status.write_flush_pending_flag)
		else $error("flush flag timing wrong");
	chk_enable_bits: assert property (
		cmd_wr |=> status.translation_on_flag == last_wd[31] && status.adv_fault_logging_on_flag == last_wd[28]
		&& status.queued_invalidation_on_flag == last_wd[26] && status.irq_remap_on_flag == last_wd[25]
		&& status.compat_irq_pass_flag == last_wd[23]) else $error("enable bits wrong");
	chk_one_wait: assert property (
		apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready
		##1 !apb_rsp.pready) else $error("apb wait state wrong");
	chk_status_ro: assert property (
		done && apb_req.pwrite && apb_req.paddr == RGSRT_OFS_STS
		|-> apb_rsp.pslverr) else $error("status write accepted");
	chk_active_hold: assert property (
		!$rose(status.root_pointer_set_flag) |-> $stable(active_root_base) && $stable(active_ttm))
		else $error("active root changed without command");
	chk_mode_decode: assert property (
		active_ttm_legacy == (active_ttm == RGSRT_TTM_LEGACY)
		&& active_ttm_scalable == (active_ttm == RGSRT_TTM_SCALABLE))
		else $error("mode decode wrong");
endmodule
bind rgsrt_top rgsrt_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (
	.clock(clock), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.status(status), .active_root_base(active_root_base),
	.active_ttm(active_ttm), .active_ttm_legacy(active_ttm_legacy),
	.active_ttm_scalable(active_ttm_scalable));
`default_nettype wire

// File: tb/rgsrt_tb_top.sv
// self-checking bench for the remap status and root table registers
`timescale 1ns/1ps
`default_nettype none
module rgsrt_tb_top;
	import rgsrt_pkg::*;
	localparam int OPC = 4; // operation latency, same as the package default
	logic clock = 1'b0;
	logic nrst = 1'b0; // held low at start
	rgsrt_apb_req_t req = '0;
	rgsrt_apb_rsp_t rsp;
	rgsrt_status_t status;
	logic [63:12] flp = 52'h0000abcdef012; // fault log pointer fed in
	logic [63:12] itb = '1; // all ones, so the width mask shows
	logic [63:12] arb, afp, aib;
	logic [1:0] attm;
	logic alg, asc;
	int num_errors = 0;
	int total_checks = 0;
	logic [31:0] rd_data;
	logic rd_err;
	rgsrt_top #(.OP_CYCLES(8'(OPC))) uut (.clock(clock), .nrst(nrst),
		.apb_req(req), .apb_rsp(rsp), .fault_log_ptr(flp),
		.irq_table_base(itb), .status(status), .active_root_base(arb),
		.active_ttm(attm), .active_ttm_legacy(alg),
		.active_ttm_scalable(asc), .active_fault_log_ptr(afp),
		.active_irq_table_base(aib));
	initial forever #2 clock = ~clock;
	// compare one result, count it, report a mismatch
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; pready, data and error are taken at the
	// rising edge that ends it, and only then is the request dropped
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		chk("pready", 64'h1, 64'(rsp.pready));
		rd_data = rsp.prdata;
		rd_err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp,
		input logic err);
		apb(1'b0, a, 32'h0);
		chk("prdata", 64'(exp), 64'(rd_data));
		chk("pslverr", 64'(err), 64'(rd_err));
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic err);
		apb(1'b1, a, d);
		chk("pslverr", 64'(err), 64'(rd_err));
	endtask
	// start one handshake and follow its flag to completion
	task automatic op(input int b);
		logic [8:0] s;
		logic inv;
		inv = (b == RGSRT_BIT_WBF);
		wr(RGSRT_OFS_CMD, 32'h1 << b, 1'b0);
		@(negedge clock);
		s = status;
		chk("flag at start", 64'(inv), 64'(s[b-23]));
		repeat (OPC) @(posedge clock);
		@(negedge clock);
		s = status;
		chk("flag at end", 64'(!inv), 64'(s[b-23]));
	endtask
	task automatic t_reset();
		rd(RGSRT_OFS_STS, 32'h0, 1'b0);
		rd(RGSRT_OFS_RTA_LO, 32'h0, 1'b0);
		rd(RGSRT_OFS_RTA_HI, 32'h0, 1'b0);
		wr(RGSRT_OFS_STS, 32'hffff_ffff, 1'b1);
		rd(RGSRT_OFS_STS, 32'h0, 1'b0);
		rd(12'h040, 32'h0, 1'b1);
		rd(RGSRT_OFS_CMD, 32'h0, 1'b0);
		chk("legacy after reset", 64'h1, 64'(alg));
	endtask
	// stored address bits, reserved and unimplemented ones read zero
	task automatic t_addr();
		wr(RGSRT_OFS_RTA_LO, 32'hffff_ffff, 1'b0);
		wr(RGSRT_OFS_RTA_HI, 32'hffff_ffff, 1'b0);
		rd(RGSRT_OFS_RTA_LO, 32'hffff_fc00, 1'b0);
		rd(RGSRT_OFS_RTA_HI, 32'h0000_ffff, 1'b0);
		chk("active base held", 64'h0, 64'(arb));
	endtask
	// adopt the root table once in every mode code; translation
	// stays off throughout, so the mode field may change
	task automatic t_root();
		logic [31:0] lo;
		for (int m = 0; m < 4; m++) begin
			lo = 32'h1234_5000 | (32'(m) << RGSRT_TTM_LSB);
			chk("translation off", 64'h0, 64'(status.translation_on_flag));
			wr(RGSRT_OFS_RTA_LO, lo, 1'b0);
			wr(RGSRT_OFS_RTA_HI, 32'h0000_00ab, 1'b0);
			op(RGSRT_BIT_RTP);
			chk("active base", 64'h0ab1_2345, 64'(arb));
			chk("active mode", 64'(m), 64'(attm));
			chk("legacy", 64'(m == 0), 64'(alg));
			chk("scalable", 64'(m == 1), 64'(asc));
		end
	endtask
	// fault log, irq table and flush handshakes, twice to see the clear
	task automatic t_ops();
		for (int i = 0; i < 2; i++) begin
			op(RGSRT_BIT_FLOG);
			op(RGSRT_BIT_IRTP);
			op(RGSRT_BIT_WBF);
		end
		chk("fault log copy", 64'(flp), 64'(afp));
		chk("irq table copy", 64'h000f_ffff_ffff, 64'(aib));
	endtask
	// enable bits follow the command word; left off at the end
	task automatic t_direct();
		logic [31:0] p [3];
		p = '{32'h9680_0000, 32'h8480_0000, 32'h0};
		for (int i = 0; i < 3; i++) begin
			wr(RGSRT_OFS_CMD, p[i], 1'b0);
			rd(RGSRT_OFS_STS, p[i] | 32'h6100_0000, 1'b0);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_addr();
		t_root();
		t_ops();
		t_direct();
		end_of_test();
	end
	// the scenarios need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clock);
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
